/* File: design/tb16_pkg.sv */
/*
  Package for the 16-bit timer byte access block: byte offsets of the
  eight byte locations, count limits, TOP selections and the bus carrier.
  Assumes a single clock domain and an 8-bit CPU data bus.
*/
package tb16_pkg;

  localparam logic [2:0] TB16_CNT_LO = 3'h0;
  localparam logic [2:0] TB16_CNT_HI = 3'h1;
  localparam logic [2:0] TB16_CAP_LO = 3'h2;
  localparam logic [2:0] TB16_CAP_HI = 3'h3;
  localparam logic [2:0] TB16_CMA_LO = 3'h4;
  localparam logic [2:0] TB16_CMA_HI = 3'h5;
  localparam logic [2:0] TB16_CMB_LO = 3'h6;
  localparam logic [2:0] TB16_CMB_HI = 3'h7;

  localparam logic [15:0] TB16_BOTTOM   = 16'h0000;
  localparam logic [15:0] TB16_MAX      = 16'hffff;
  localparam logic [15:0] TB16_TOP_8B   = 16'h00ff;
  localparam logic [15:0] TB16_TOP_9B   = 16'h01ff;
  localparam logic [15:0] TB16_TOP_10B  = 16'h03ff;
  localparam logic [15:0] TB16_RST_WORD = 16'h0000;
  localparam logic [7:0]  TB16_RST_BYTE = 8'h00;

  // TOP source selection
  typedef enum logic [2:0] {
    TB16_TOPSEL_8B  = 3'h0,
    TB16_TOPSEL_9B  = 3'h1,
    TB16_TOPSEL_10B = 3'h2,
    TB16_TOPSEL_CMA = 3'h3,
    TB16_TOPSEL_CAP = 3'h4
  } tb16_topsel_e;

  // One CPU byte access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tb16_cpu_s;

  // Requests from the counting and capture logic
  typedef struct packed {
    logic        cnt_load;
    logic [15:0] cnt_value;
    logic        cap_load;
    logic [15:0] cap_value;
  } tb16_core_s;

endpackage

/* File: design/tb16_access.sv */
/*
  Byte-wide access path to the counter, two compare registers and the
  capture register of a 16-bit timer, with the shared high-byte latch and
  the BOTTOM, MAX and TOP decodes.
  Assumes the counting and capture logic sits outside on the same clock and
  hands in its next counter value and capture events each cycle.
*/
`timescale 1ns/1ps
module tb16_access (
  input  wire logic                  clk_sys,      // System clock, 200 MHz
  input  wire logic                  rst_b,        // Async reset, active low
  input  wire tb16_pkg::tb16_cpu_s   cpu,          // CPU byte access
  input  wire tb16_pkg::tb16_core_s  core,         // Count and capture updates
  input  wire tb16_pkg::tb16_topsel_e top_sel,     // TOP source
  output logic [7:0]                 rdata,        // Read byte, one cycle later
  output logic [15:0]                timer_count_value, // Counter
  output logic [15:0]                compare_value_a,   // Compare A
  output logic [15:0]                compare_value_b,   // Compare B
  output logic [15:0]                capture_value,     // Capture
  output logic [15:0]                top_value,    // Current TOP
  output logic                       at_bottom,    // Counter is zero
  output logic                       at_max,       // Counter is all ones
  output logic                       at_top        // Counter equals TOP
);
  import tb16_pkg::*;

  logic [7:0]  high_latch;
  logic [7:0]  next_high_latch;
  logic [7:0]  next_rdata;
  logic [15:0] next_cnt;
  logic [15:0] next_cma;
  logic [15:0] next_cmb;
  logic [15:0] next_cap;
  logic [15:0] next_top;
  logic        next_bottom;
  logic        next_max;
  logic        next_top_hit;

  // Register and latch updates; CPU writes win over the core
  always_comb begin
    next_high_latch = high_latch;
    next_cnt        = core.cnt_load ? core.cnt_value : timer_count_value;
    next_cma        = compare_value_a;
    next_cmb        = compare_value_b;
    next_cap        = core.cap_load ? core.cap_value : capture_value;
    next_rdata      = TB16_RST_BYTE;
    if (cpu.wr) begin
      case (cpu.addr)
        TB16_CNT_LO: next_cnt = {high_latch, cpu.wdata};
        TB16_CAP_LO: next_cap = {high_latch, cpu.wdata};
        TB16_CMA_LO: next_cma = {high_latch, cpu.wdata};
        TB16_CMB_LO: next_cmb = {high_latch, cpu.wdata};
        default:     next_high_latch = cpu.wdata;
      endcase
    end else if (cpu.rd) begin
      case (cpu.addr)
        TB16_CNT_LO: begin
          next_rdata      = timer_count_value[7:0];
          next_high_latch = timer_count_value[15:8];
        end
        TB16_CAP_LO: begin
          next_rdata      = capture_value[7:0];
          next_high_latch = capture_value[15:8];
        end
        TB16_CMA_LO: next_rdata = compare_value_a[7:0];
        TB16_CMA_HI: next_rdata = compare_value_a[15:8];
        TB16_CMB_LO: next_rdata = compare_value_b[7:0];
        TB16_CMB_HI: next_rdata = compare_value_b[15:8];
        default:     next_rdata = high_latch;
      endcase
    end
  end

  // TOP source and count decodes, taken from the next counter value
  always_comb begin
    case (top_sel)
      TB16_TOPSEL_8B:  next_top = TB16_TOP_8B;
      TB16_TOPSEL_9B:  next_top = TB16_TOP_9B;
      TB16_TOPSEL_10B: next_top = TB16_TOP_10B;
      TB16_TOPSEL_CMA: next_top = next_cma;
      TB16_TOPSEL_CAP: next_top = next_cap;
      default:         next_top = TB16_TOP_8B;
    endcase
    next_bottom  = (next_cnt == TB16_BOTTOM);
    next_max     = (next_cnt == TB16_MAX);
    next_top_hit = (next_cnt == next_top);
  end

  // State registers; flags line up with the counter they describe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      high_latch        <= TB16_RST_BYTE;
      rdata             <= TB16_RST_BYTE;
      timer_count_value <= TB16_RST_WORD;
      compare_value_a   <= TB16_RST_WORD;
      compare_value_b   <= TB16_RST_WORD;
      capture_value     <= TB16_RST_WORD;
      top_value         <= TB16_TOP_8B;
      at_bottom         <= 1'b1;
      at_max            <= 1'b0;
      at_top            <= 1'b0;
    end else begin
      high_latch        <= next_high_latch;
      rdata             <= next_rdata;
      timer_count_value <= next_cnt;
      compare_value_a   <= next_cma;
      compare_value_b   <= next_cmb;
      capture_value     <= next_cap;
      top_value         <= next_top;
      at_bottom         <= next_bottom;
      at_max            <= next_max;
      at_top            <= next_top_hit;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_hi_write;
    cpu.wr && cpu.addr == TB16_CNT_HI;
  endsequence
  sequence s_lo_write;
    cpu.wr && cpu.addr == TB16_CNT_LO;
  endsequence

  property p_bottom;
    at_bottom == (timer_count_value == 16'h0000);
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom flag wrong");

  property p_max;
    at_max == (timer_count_value == 16'hffff);
  endproperty
  a_max: assert property (p_max) else $error("max flag wrong");

  property p_top_fixed;
    top_sel == TB16_TOPSEL_9B |=> top_value == 16'h01ff;
  endproperty
  a_top_fixed: assert property (p_top_fixed) else $error("fixed top wrong");

  property p_pair_write;
    s_hi_write ##1 (s_lo_write and !core.cnt_load)
      |=> timer_count_value == {$past(cpu.wdata, 2), $past(cpu.wdata)};
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("pair write lost");

  property p_lo_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CAP_LO
      |=> high_latch == $past(capture_value[15:8]) && rdata == $past(capture_value[7:0]);
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("latch not captured");

  property p_cmp_read;
    cpu.rd && !cpu.wr && cpu.addr[2] |=> $stable(high_latch);
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("compare read touched latch");

  property p_hi_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CNT_HI |=> rdata == $past(high_latch);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high read not latch");

  property p_prio;
    s_lo_write and core.cnt_load
      |=> timer_count_value == {$past(high_latch), $past(cpu.wdata)};
  endproperty
  a_prio: assert property (p_prio) else $error("cpu write lost priority");

  property p_hi_only;
    s_hi_write and !core.cnt_load |=> $stable(timer_count_value);
  endproperty
  a_hi_only: assert property (p_hi_only) else $error("high write hit register");

  // Back-to-back capture read; the high byte must come from the frozen copy
  sequence s_cap_lo_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CAP_LO;
  endsequence
  sequence s_cap_hi_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CAP_HI;
  endsequence

  property p_read_pair;
    s_cap_lo_read ##1 s_cap_hi_read |=> rdata == $past(capture_value[15:8], 2);
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("capture pair read torn");

  property p_cnt_lo_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CNT_LO
      |=> high_latch == $past(timer_count_value[15:8])
          && rdata == $past(timer_count_value[7:0]);
  endproperty
  a_cnt_lo_read: assert property (p_cnt_lo_read) else $error("count latch not captured");

  property p_cma_write;
    cpu.wr && cpu.addr == TB16_CMA_LO
      |=> compare_value_a == {$past(high_latch), $past(cpu.wdata)};
  endproperty
  a_cma_write: assert property (p_cma_write) else $error("compare a write lost");

  property p_cmb_write;
    cpu.wr && cpu.addr == TB16_CMB_LO
      |=> compare_value_b == {$past(high_latch), $past(cpu.wdata)};
  endproperty
  a_cmb_write: assert property (p_cmb_write) else $error("compare b write lost");

  property p_cap_write;
    cpu.wr && cpu.addr == TB16_CAP_LO
      |=> capture_value == {$past(high_latch), $past(cpu.wdata)};
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("capture write lost");

  property p_cmp_hi_read;
    cpu.rd && !cpu.wr && cpu.addr == TB16_CMA_HI |=> rdata == $past(compare_value_a[15:8]);
  endproperty
  a_cmp_hi_read: assert property (p_cmp_hi_read) else $error("compare high read wrong");

  property p_top_cma;
    top_sel == TB16_TOPSEL_CMA |=> top_value == compare_value_a;
  endproperty
  a_top_cma: assert property (p_top_cma) else $error("top not compare a");

  property p_top_cap;
    top_sel == TB16_TOPSEL_CAP |=> top_value == capture_value;
  endproperty
  a_top_cap: assert property (p_top_cap) else $error("top not capture");

  property p_top_hit;
    at_top == (timer_count_value == top_value);
  endproperty
  a_top_hit: assert property (p_top_hit) else $error("top flag wrong");

  property p_no_read;
    !cpu.rd || cpu.wr |=> rdata == TB16_RST_BYTE;
  endproperty
  a_no_read: assert property (p_no_read) else $error("read byte without read");

endmodule

/* File: tb/tb16_cpu_model.sv */
/*
  CPU core model: byte reads and writes on the timer access path.
  Assumes one caller at a time and the block's one-cycle read answer.
*/
`timescale 1ns/1ps
module tb16_cpu_model (
  input  wire logic           clk_sys, // System clock
  input  wire logic [7:0]     rdata,   // Read byte from block
  output tb16_pkg::tb16_cpu_s cpu      // Byte access to block
);
  import tb16_pkg::*;
  initial cpu = '0;
  // One access, raised after a falling edge, taken at the next rising edge
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_sys);
    cpu.rd    = !w;
    cpu.wr    = w;
    cpu.addr  = a;
    cpu.wdata = d;
    @(negedge clk_sys);
    q = rdata;
    // Released lines show a changed pattern, never the old value
    cpu.rd    = 1'b0;
    cpu.wr    = 1'b0;
    cpu.addr  = ~a;
    cpu.wdata = ~d;
  endtask
  // Whole words only, never interleaved with another caller
  // Strobe held across both bytes so the pair lands on adjacent edges
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    @(negedge clk_sys);
    cpu.rd    = 1'b0;
    cpu.wr    = 1'b1;
    cpu.addr  = lo + 3'h1;
    cpu.wdata = v[15:8];
    @(negedge clk_sys);
    cpu.addr  = lo;
    cpu.wdata = v[7:0];
    @(negedge clk_sys);
    cpu.wr    = 1'b0;
    cpu.addr  = ~lo;
    cpu.wdata = ~v[7:0];
  endtask
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    logic [7:0] l, h;
    @(negedge clk_sys);
    cpu.rd    = 1'b1;
    cpu.wr    = 1'b0;
    cpu.addr  = lo;
    cpu.wdata = 8'h00;
    @(negedge clk_sys);
    l = rdata;
    cpu.addr  = lo + 3'h1;
    @(negedge clk_sys);
    h = rdata;
    cpu.rd    = 1'b0;
    cpu.addr  = ~lo;
    cpu.wdata = 8'hff;
    v = {h, l};
  endtask
endmodule

/* File: tb/tb16_access_tb_top.sv */
/*
  Testbench of the timer byte access path: CPU model plus core stimulus.
  Assumes the registered read answer and flag timing of the block.
*/
`timescale 1ns/1ps
module tb16_access_tb_top;
  import tb16_pkg::*;
  logic         clk_sys, rst_b, bot, mx, at_t;
  tb16_cpu_s    cpu;
  tb16_core_s   core;
  tb16_topsel_e top_sel;
  logic [7:0]   rdata, q;
  logic [15:0]  cnt, cma, cmb, cap, top, v;
  int           errors, cmp_count, cyc;

  tb16_access tb16_access_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cpu(cpu), .core(core),
    .top_sel(top_sel), .rdata(rdata), .timer_count_value(cnt), .compare_value_a(cma),
    .compare_value_b(cmb), .capture_value(cap), .top_value(top), .at_bottom(bot),
    .at_max(mx), .at_top(at_t));
  tb16_cpu_model tb16_cpu_model_inst (.clk_sys(clk_sys), .rdata(rdata), .cpu(cpu));

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp_v);
    cmp_count++;
    if (got !== exp_v) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp_v);
    chk_w({15'h0000, got}, {15'h0000, exp_v});
  endtask
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Latch only on high write; CPU write beats a core load
  task automatic t_write;
    tb16_cpu_model_inst.acc(1'b1, TB16_CNT_HI, 8'h01, q);
    chk_w(cnt, TB16_RST_WORD);
    tb16_cpu_model_inst.acc(1'b0, TB16_CNT_HI, 8'h00, q);
    chk_w({8'h00, q}, 16'h0001);
    core.cnt_load  = 1'b1;
    core.cnt_value = 16'h1234;
    tb16_cpu_model_inst.acc(1'b1, TB16_CNT_LO, 8'hff, q);
    chk_w(cnt, 16'h01ff);
    core.cnt_load = 1'b0;
    tb16_cpu_model_inst.wr16(TB16_CNT_LO, 16'h0a5c);
    chk_w(cnt, 16'h0a5c);
  endtask
  // Every TOP source, then the limit flags
  task automatic t_top;
    logic [15:0] tv [5];
    tv = '{TB16_TOP_8B, TB16_TOP_9B, TB16_TOP_10B, 16'h2345, 16'h3456};
    tb16_cpu_model_inst.wr16(TB16_CMA_LO, 16'h2345);
    core.cap_load  = 1'b1;
    core.cap_value = 16'h3456;
    @(negedge clk_sys);
    core.cap_load = 1'b0;
    chk_w(cap, 16'h3456);
    core.cnt_load = 1'b1;
    for (int i = 0; i < 5; i++) begin
      top_sel        = tb16_topsel_e'(i);
      core.cnt_value = tv[i];
      repeat (3) @(negedge clk_sys);
      chk_w(top, tv[i]);
      chk_b(at_t, 1'b1);
    end
    core.cnt_value = TB16_MAX;
    repeat (3) @(negedge clk_sys);
    chk_b(mx, 1'b1);
    chk_b(at_t, 1'b0);
    chk_b(bot, 1'b0);
    core.cnt_value = TB16_BOTTOM;
    repeat (3) @(negedge clk_sys);
    chk_b(bot, 1'b1);
    chk_b(mx, 1'b0);
    core.cnt_load = 1'b0;
  endtask
  // Low read freezes the high byte; compare reads leave the latch
  task automatic t_read;
    core.cnt_load  = 1'b1;
    core.cnt_value = 16'habcd;
    @(negedge clk_sys);
    core.cnt_load = 1'b0;
    tb16_cpu_model_inst.acc(1'b0, TB16_CNT_LO, 8'h00, q);
    chk_w({8'h00, q}, 16'h00cd);
    core.cnt_load  = 1'b1;
    core.cnt_value = 16'h5500;
    @(negedge clk_sys);
    core.cnt_load = 1'b0;
    tb16_cpu_model_inst.acc(1'b0, TB16_CNT_HI, 8'h00, q);
    chk_w({8'h00, q}, 16'h00ab);
    tb16_cpu_model_inst.rd16(TB16_CAP_LO, v);
    chk_w(v, 16'h3456);
    tb16_cpu_model_inst.rd16(TB16_CMA_LO, v);
    chk_w(v, 16'h2345);
    tb16_cpu_model_inst.acc(1'b0, TB16_CNT_HI, 8'h00, q);
    chk_w({8'h00, q}, 16'h0034);
  endtask
  // One latch write reused for several low bytes and registers
  task automatic t_share;
    tb16_cpu_model_inst.acc(1'b1, TB16_CMA_HI, 8'h77, q);
    tb16_cpu_model_inst.acc(1'b1, TB16_CMA_LO, 8'h11, q);
    tb16_cpu_model_inst.acc(1'b1, TB16_CMB_LO, 8'h22, q);
    chk_w(cma, 16'h7711);
    chk_w(cmb, 16'h7722);
    tb16_cpu_model_inst.acc(1'b1, TB16_CAP_HI, 8'h66, q);
    tb16_cpu_model_inst.acc(1'b1, TB16_CAP_LO, 8'h55, q);
    chk_w(cap, 16'h6655);
    tb16_cpu_model_inst.acc(1'b1, TB16_CNT_LO, 8'h00, q);
    chk_w(cnt, 16'h6600);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Ceiling well above the roughly 80 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    rst_b   = 1'b0;
    core    = '0;
    top_sel = TB16_TOPSEL_8B;
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    chk_w(top, TB16_TOP_8B);
    chk_b(bot, 1'b1);
    t_write();
    t_top();
    t_read();
    t_share();
    end_sim();
  end
endmodule
